/* mcr_pkg.sv */
// mcr_pkg: shared constants of the misc control register bank
package mcr_pkg;

    // ------------------------------------------------
    // bus geometry
    // ------------------------------------------------
    localparam int ADDR_W = 12; // byte address width
    localparam int DATA_W = 32; // bus data width

    // ------------------------------------------------
    // register byte offsets
    // ------------------------------------------------
    localparam logic [11:0] OFS_ENGINE_RESET = 12'h020;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'h0a8;
    localparam logic [11:0] OFS_IRQ_GLOBAL = 12'h0ac;
    localparam logic [11:0] OFS_IRQ_SOURCE = 12'h0b0;
    localparam logic [11:0] OFS_BL_FREQ = 12'h0d0;
    localparam logic [11:0] OFS_BL_DUTY = 12'h0d4;
    localparam logic [11:0] OFS_SUBST_0 = 12'h0d8;
    localparam logic [11:0] OFS_SUBST_1 = 12'h0dc;

    // ------------------------------------------------
    // field positions and widths
    // ------------------------------------------------
    localparam int BIT_COPROC = 0; // command engine reset
    localparam int BIT_TOUCH = 1; // touch engine reset
    localparam int BIT_AUDIO = 2; // audio engine reset
    localparam int BIT_GLOBAL_EN = 0; // global irq enable
    localparam int ENG_W = 3; // engine reset field
    localparam int IRQ_W = 8; // interrupt sources
    localparam int FREQ_W = 14; // pwm frequency field
    localparam int DUTY_W = 8; // pwm duty field
    localparam int DL_ADDR_W = 13; // display list index

    // ------------------------------------------------
    // reset values
    // ------------------------------------------------
    localparam logic [2:0] RST_ENGINE = 3'h0;
    localparam logic [7:0] RST_IRQ_MASK = 8'hff;
    localparam logic [13:0] RST_BL_FREQ = 14'h00fa;
    localparam logic [7:0] RST_BL_DUTY = 8'h80;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------
    // backlight pwm timing
    // ------------------------------------------------
    localparam logic [31:0] CLK_HZ = 32'h0262_5a00; // 40 MHz system clock
    localparam logic [7:0] DUTY_FULL = 8'h80; // full brightness step count
    localparam int DUTY_SHIFT = 7; // divide by 128

endpackage : mcr_pkg

/* mcr_backlight_pwm.sv */
// mcr_backlight_pwm: backlight pwm driven by a frequency in hertz
module mcr_backlight_pwm #(
    parameter logic [31:0] CLK_HZ = mcr_pkg::CLK_HZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [13:0] freq_hz,
    input wire logic [7:0] duty,
    output logic pwm_out
);

    // ------------------------------------------------
    // phase accumulator
    // ------------------------------------------------
    // the phase grows by freq_hz each clock and wraps at CLK_HZ,
    // so one wrap equals one pwm period with no divider needed;
    // CLK_HZ must stay above the largest frequency or the phase never settles
    logic [31:0] phase_reg;
    logic [32:0] phase_sum;
    logic [7:0] duty_clip; // duty above 128 acts as 128
    logic [39:0] phase_scaled; // phase times 128
    logic [39:0] duty_scaled; // duty times clock rate

    assign phase_sum = {1'b0, phase_reg} + {19'h0_0000, freq_hz};
    assign duty_clip = (duty > mcr_pkg::DUTY_FULL) ? mcr_pkg::DUTY_FULL : duty;
    assign phase_scaled = {8'h00, phase_reg} << mcr_pkg::DUTY_SHIFT;
    assign duty_scaled = {32'h0000_0000, duty_clip} * {8'h00, CLK_HZ};

    // advance the phase and wrap it once per period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_reg <= 32'h0000_0000;
        end else if (phase_sum >= {1'b0, CLK_HZ}) begin
            phase_reg <= 32'(phase_sum - {1'b0, CLK_HZ});
        end else begin
            phase_reg <= phase_sum[31:0];
        end
    end

    // high for duty/128 of each period; duty 0 never high [RULE15] [RULE6]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (phase_scaled < duty_scaled);
        end
    end

endmodule : mcr_backlight_pwm

/* mcr_irq_unit.sv */
// mcr_irq_unit: sticky interrupt flags, source mask and global enable
module mcr_irq_unit #(
    parameter int N_SRC = mcr_pkg::IRQ_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [N_SRC-1:0] src_event,
    input wire logic flags_read,
    input wire logic [N_SRC-1:0] src_mask,
    input wire logic global_en,
    output logic [N_SRC-1:0] flags,
    output logic irq_out
);

    // ------------------------------------------------
    // sticky flags
    // ------------------------------------------------
    logic [N_SRC-1:0] flags_next;

    // a read clears the flags, but an event in that same cycle survives
    always_comb begin
        flags_next = flags;
        if (flags_read) begin
            flags_next = '0; // [RULE14]
        end
        flags_next = flags_next | src_event;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags <= flags_next;
        end
    end

    // ------------------------------------------------
    // interrupt output
    // ------------------------------------------------
    // masked flags gated by the global enable [RULE11] [RULE13] [RULE16]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= global_en & (|(flags & src_mask));
        end
    end

endmodule : mcr_irq_unit

/* mcr_misc_regs.sv */
// mcr_misc_regs: misc control register bank on a classic wishbone slave
//
// Function
// RULE1 - bits 0,1,2: command, touch, audio engine
// RULE2 - write one holds reset, zero releases
// RULE3 - read shows one while engine held
// RULE4 - parameter one substitutes second word
// RULE5 - parameter zero substitutes first word
// RULE6 - duty 0 off, 128 full brightness
// RULE7 - duty in low eight bits only
// RULE8 - frequency is fourteen bits, in hertz
// RULE9 - backlight runs 250 Hz after reset
// RULE10 - software keeps frequency at least 25 Hz
// RULE11 - mask bit one passes its source
// RULE12 - all mask bits one after reset
// RULE13 - global enable bit 0 gates interrupt
// RULE14 - flags clear on read, never written
// RULE15 - high time is duty over 128
// RULE16 - interrupt when enabled masked flag set
//
// Implementation choice: the Wishbone slave port.
module mcr_misc_regs #(
    parameter logic [31:0] CLK_HZ = mcr_pkg::CLK_HZ
) (
    input wire logic clk,
    input wire logic reset_n,
    // classic wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // engine reset holds
    output logic coproc_reset,
    output logic touch_reset,
    output logic audio_reset,
    // display list substitution
    input wire logic subst_req,
    input wire logic subst_param,
    input wire logic [12:0] subst_addr,
    output logic dl_wr_en,
    output logic [12:0] dl_wr_addr,
    output logic [31:0] dl_wr_data,
    // interrupt sources and output
    input wire logic [7:0] irq_event,
    output logic irq_out,
    // backlight pin
    output logic backlight_pwm
);

    // ------------------------------------------------
    // helper functions
    // ------------------------------------------------

    // merge write data into an old word by byte lanes
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // word decode that ignores the two byte address bits
    function automatic logic hit(
        input logic [11:0] adr,
        input logic [11:0] ofs
    );
        return adr[11:2] == ofs[11:2];
    endfunction : hit

    // ------------------------------------------------
    // register state
    // ------------------------------------------------
    logic [2:0] engine_reset_reg; // engine reset holds
    logic irq_global_reg; // global interrupt enable
    logic [7:0] irq_mask_reg; // per source enables
    logic [13:0] bl_freq_reg; // pwm frequency, hertz
    logic [7:0] bl_duty_reg; // pwm duty steps
    logic [31:0] subst0_reg; // substitution word 0
    logic [31:0] subst1_reg; // substitution word 1
    logic ack_reg; // bus answer
    logic [31:0] rd_reg; // bus read data
    logic [31:0] rd_next; // read data mux
    logic [7:0] irq_flags; // sticky flags from irq unit
    logic irq_reg; // interrupt level from irq unit
    logic pwm_reg; // pwm level from pwm unit

    // ------------------------------------------------
    // bus access decode
    // ------------------------------------------------
    logic bus_take; // request taken this edge
    logic wr_take; // write taken this edge
    logic rd_take; // read taken this edge
    logic flags_rd; // flag register read this edge
    logic [31:0] wr_merged_eng; // merged write, engine reg
    logic [31:0] wr_merged_glb; // merged write, global enable
    logic [31:0] wr_merged_msk; // merged write, mask
    logic [31:0] wr_merged_frq; // merged write, frequency
    logic [31:0] wr_merged_dty; // merged write, duty

    // a request is taken in the cycle before ack; ack then drops
    // for one cycle, so every access costs exactly two edges
    assign bus_take = wb_cyc & wb_stb & ~ack_reg;
    assign wr_take = bus_take & wb_we;
    assign rd_take = bus_take & ~wb_we;
    assign flags_rd = rd_take & hit(wb_adr, mcr_pkg::OFS_IRQ_FLAGS);

    // narrow registers merge against zero-extended old values
    assign wr_merged_eng = lane_merge({29'h0, engine_reset_reg}, wb_dat_w, wb_sel);
    assign wr_merged_glb = lane_merge({31'h0, irq_global_reg}, wb_dat_w, wb_sel);
    assign wr_merged_msk = lane_merge({24'h00_0000, irq_mask_reg}, wb_dat_w, wb_sel);
    assign wr_merged_frq = lane_merge({18'h0_0000, bl_freq_reg}, wb_dat_w, wb_sel);
    assign wr_merged_dty = lane_merge({24'h00_0000, bl_duty_reg}, wb_dat_w, wb_sel);

    // ------------------------------------------------
    // bus answer
    // ------------------------------------------------

    // one ack per taken request, mapped or not
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_take;
        end
    end

    // ------------------------------------------------
    // engine reset holds
    // ------------------------------------------------

    // one bit per engine, each drives only its own hold [RULE1] [RULE2]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            engine_reset_reg <= mcr_pkg::RST_ENGINE;
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_ENGINE_RESET)) begin
            engine_reset_reg <= wr_merged_eng[2:0];
        end
    end

    // hold outputs are registered copies of the register bits, one clock later
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            coproc_reset <= 1'b0;
            touch_reset <= 1'b0;
            audio_reset <= 1'b0;
        end else begin
            coproc_reset <= engine_reset_reg[mcr_pkg::BIT_COPROC]; // [RULE1]
            touch_reset <= engine_reset_reg[mcr_pkg::BIT_TOUCH]; // [RULE1]
            audio_reset <= engine_reset_reg[mcr_pkg::BIT_AUDIO]; // [RULE1]
        end
    end

    // ------------------------------------------------
    // interrupt enables
    // ------------------------------------------------

    // global enable, bit 0 only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_global_reg <= 1'b0;
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_IRQ_GLOBAL)) begin
            irq_global_reg <= wr_merged_glb[mcr_pkg::BIT_GLOBAL_EN]; // [RULE13]
        end
    end

    // source mask starts all open [RULE12]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_mask_reg <= mcr_pkg::RST_IRQ_MASK; // [RULE12]
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_IRQ_SOURCE)) begin
            irq_mask_reg <= wr_merged_msk[7:0]; // [RULE11]
        end
    end

    // ------------------------------------------------
    // backlight settings
    // ------------------------------------------------

    // frequency in hertz; values under 25 Hz are the caller's fault
    // and are stored as given, the pwm simply runs slower [RULE10]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bl_freq_reg <= mcr_pkg::RST_BL_FREQ; // [RULE9]
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_BL_FREQ)) begin
            bl_freq_reg <= wr_merged_frq[13:0]; // [RULE8]
        end
    end

    // duty holds eight bits; values above 128 clip in the pwm unit
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bl_duty_reg <= mcr_pkg::RST_BL_DUTY;
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_BL_DUTY)) begin
            bl_duty_reg <= wr_merged_dty[7:0]; // [RULE7]
        end
    end

    // ------------------------------------------------
    // substitution words
    // ------------------------------------------------

    // word 0, full width
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            subst0_reg <= mcr_pkg::RST_WORD;
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_SUBST_0)) begin
            subst0_reg <= lane_merge(subst0_reg, wb_dat_w, wb_sel);
        end
    end

    // word 1, full width
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            subst1_reg <= mcr_pkg::RST_WORD;
        end else if (wr_take && hit(wb_adr, mcr_pkg::OFS_SUBST_1)) begin
            subst1_reg <= lane_merge(subst1_reg, wb_dat_w, wb_sel);
        end
    end

    // ------------------------------------------------
    // display list substitution write
    // ------------------------------------------------

    // the builder asks once per substitution command; the chosen word
    // goes out one cycle later in place of the command
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dl_wr_en <= 1'b0;
            dl_wr_addr <= 13'h0000;
            dl_wr_data <= mcr_pkg::RST_WORD;
        end else begin
            dl_wr_en <= subst_req;
            if (subst_req) begin
                dl_wr_addr <= subst_addr;
                if (subst_param) begin
                    dl_wr_data <= subst1_reg; // [RULE4]
                end else begin
                    dl_wr_data <= subst0_reg; // [RULE5]
                end
            end
        end
    end

    // ------------------------------------------------
    // read data
    // ------------------------------------------------

    // unmapped addresses and reserved bits read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (hit(wb_adr, mcr_pkg::OFS_ENGINE_RESET)) begin
            rd_next[2:0] = engine_reset_reg; // [RULE3]
        end else if (hit(wb_adr, mcr_pkg::OFS_IRQ_FLAGS)) begin
            rd_next[7:0] = irq_flags;
        end else if (hit(wb_adr, mcr_pkg::OFS_IRQ_GLOBAL)) begin
            rd_next[mcr_pkg::BIT_GLOBAL_EN] = irq_global_reg;
        end else if (hit(wb_adr, mcr_pkg::OFS_IRQ_SOURCE)) begin
            rd_next[7:0] = irq_mask_reg;
        end else if (hit(wb_adr, mcr_pkg::OFS_BL_FREQ)) begin
            rd_next[13:0] = bl_freq_reg;
        end else if (hit(wb_adr, mcr_pkg::OFS_BL_DUTY)) begin
            rd_next[7:0] = bl_duty_reg;
        end else if (hit(wb_adr, mcr_pkg::OFS_SUBST_0)) begin
            rd_next = subst0_reg;
        end else if (hit(wb_adr, mcr_pkg::OFS_SUBST_1)) begin
            rd_next = subst1_reg;
        end
    end

    // read data is captured at the taking edge and held until the
    // next read, which keeps the flag value that the read cleared
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rd_reg <= rd_next;
        end
    end

    // ------------------------------------------------
    // interrupt unit
    // ------------------------------------------------

    // writes to the flag register are acked and dropped [RULE14]
    mcr_irq_unit #(
        .N_SRC(mcr_pkg::IRQ_W)
    ) u_irq (
        .clk(clk),
        .reset_n(reset_n),
        .src_event(irq_event),
        .flags_read(flags_rd),
        .src_mask(irq_mask_reg),
        .global_en(irq_global_reg),
        .flags(irq_flags),
        .irq_out(irq_reg)
    );

    // ------------------------------------------------
    // backlight pwm
    // ------------------------------------------------

    // settings change the pwm at once, not at a period edge; a
    // glitch of one period is traded for a much smaller unit
    mcr_backlight_pwm #(
        .CLK_HZ(CLK_HZ)
    ) u_pwm (
        .clk(clk),
        .reset_n(reset_n),
        .freq_hz(bl_freq_reg),
        .duty(bl_duty_reg),
        .pwm_out(pwm_reg)
    );

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    assign wb_ack = ack_reg;
    assign wb_dat_r = rd_reg;
    assign irq_out = irq_reg;
    assign backlight_pwm = pwm_reg;

endmodule : mcr_misc_regs

/* mcr_misc_regs_sva.sv */
// mcr_misc_regs_sva: port-level assertions for the misc control register bank
module mcr_misc_regs_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic coproc_reset,
    input wire logic touch_reset,
    input wire logic audio_reset,
    input wire logic subst_req,
    input wire logic [12:0] subst_addr,
    input wire logic dl_wr_en,
    input wire logic [12:0] dl_wr_addr,
    input wire logic irq_out,
    input wire logic backlight_pwm
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic take; // request accepted at this edge
    logic wr0; // write touching byte lane 0
    assign take = wb_cyc && wb_stb && !wb_ack;
    assign wr0 = take && wb_we && wb_sel[0];
    // ack is a lone one-cycle pulse
    sequence ack_pulse;
        wb_ack ##1 !wb_ack;
    endsequence
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    chk_ack_one_cycle: assert property (take |=> ack_pulse)
        else $error("ack did not follow a taken request for one cycle");
    chk_engine_bits: assert property (
        wr0 && wb_adr == mcr_pkg::OFS_ENGINE_RESET |->
        ##2 {audio_reset, touch_reset, coproc_reset} == $past(wb_dat_w[2:0], 2))
        else $error("engine reset outputs differ from written bits");
    chk_freq_reserved: assert property (
        take && !wb_we && wb_adr == mcr_pkg::OFS_BL_FREQ |=> wb_dat_r[31:14] == 18'h0_0000)
        else $error("frequency read shows bits above the field");
    chk_duty_reserved: assert property (
        take && !wb_we && wb_adr == mcr_pkg::OFS_BL_DUTY |=> wb_dat_r[31:8] == 24'h00_0000)
        else $error("duty read shows bits above the field");
    chk_subst_answer: assert property (
        subst_req |=> dl_wr_en && dl_wr_addr == $past(subst_addr))
        else $error("substitution write missing or at wrong index");
    chk_subst_quiet: assert property (!subst_req |=> !dl_wr_en)
        else $error("display list written without a request");
    chk_irq_global_off: assert property (
        wr0 && wb_adr == mcr_pkg::OFS_IRQ_GLOBAL && !wb_dat_w[0] |-> ##2 !irq_out)
        else $error("interrupt raised with global enable cleared");
    chk_irq_mask_off: assert property (
        wr0 && wb_adr == mcr_pkg::OFS_IRQ_SOURCE && wb_dat_w[7:0] == 8'h00 |-> ##2 !irq_out)
        else $error("interrupt raised with all sources masked");
    chk_duty_off: assert property (
        wr0 && wb_adr == mcr_pkg::OFS_BL_DUTY && wb_dat_w[7:0] == 8'h00 |-> ##2 !backlight_pwm)
        else $error("backlight high with zero duty");
    chk_duty_full: assert property (
        wr0 && wb_adr == mcr_pkg::OFS_BL_DUTY && wb_dat_w[7] |-> ##2 backlight_pwm)
        else $error("backlight low with full duty");
endmodule : mcr_misc_regs_sva

bind mcr_misc_regs mcr_misc_regs_sva mcr_misc_regs_sva_inst (.clk, .reset_n, .wb_cyc,
    .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .coproc_reset,
    .touch_reset, .audio_reset, .subst_req, .subst_addr, .dl_wr_en, .dl_wr_addr, .irq_out,
    .backlight_pwm);

/* testbench.sv */
// testbench: self-checking bench for the misc control register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // signals; pwm clock 25600 Hz tops any 14-bit frequency; 100 Hz gives 256-cycle periods
    // ------------------------------------------------
    logic clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, subst_req, subst_param;
    logic coproc_reset, touch_reset, audio_reset, dl_wr_en, irq_out, backlight_pwm;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, dl_wr_data, rd;
    logic [12:0] subst_addr, dl_wr_addr;
    logic [7:0] irq_event;
    int num_errors = 0;
    int num_checks = 0;
    int cnt;
    // address, reset value and writable mask; 0x004 is unmapped
    logic [11:0] adr_t [9] = '{12'h020, 12'h0ac, 12'h0b0, 12'h0d0, 12'h0d4, 12'h0d8,
        12'h0dc, 12'h0a8, 12'h004};
    logic [31:0] rst_t [9] = '{0, 0, 32'h0000_00ff, 32'h0000_00fa, 32'h0000_0080, 0, 0, 0, 0};
    logic [31:0] msk_t [9] = '{32'h0000_0007, 32'h0000_0001, 32'h0000_00ff, 32'h0000_3fff,
        32'h0000_00ff, 32'hffff_ffff, 32'hffff_ffff, 0, 0};
    int duty_t [5] = '{0, 1, 64, 128, 200};
    int high_t [5] = '{0, 2, 128, 256, 256};
    always #12.5 clk = ~clk;
    mcr_misc_regs #(.CLK_HZ(32'h0000_6400)) mcr_misc_regs_inst (.clk, .reset_n, .wb_cyc,
        .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .coproc_reset,
        .touch_reset, .audio_reset, .subst_req, .subst_param, .subst_addr, .dl_wr_en,
        .dl_wr_addr, .dl_wr_data, .irq_event, .irq_out, .backlight_pwm);
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // classic cycle: hold everything until ack is sampled, then idle a cycle
    task automatic wb_access(input logic we, input logic [11:0] a, input logic [3:0] sel,
        input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= sel;
        wb_dat_w <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1) @(posedge clk);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb_access
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb_access(1'b1, a, 4'hf, d);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
        wb_access(1'b0, a, 4'hf, 32'h0000_0000);
        check(rd, want);
    endtask : rd_chk
    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // watchdog: the whole sequence needs about 1500 cycles
    initial begin
        repeat (8000) @(posedge clk);
        num_errors++;
        test_done();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        {clk, reset_n, wb_cyc, wb_stb, wb_we, subst_req, subst_param} = 7'h00;
        {wb_adr, wb_sel, wb_dat_w, subst_addr, irq_event} = 69'h0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // reset values, then all-ones write shows which bits stick
        for (int i = 0; i < 9; i++) rd_chk(adr_t[i], rst_t[i]);
        for (int i = 0; i < 9; i++) begin
            wr(adr_t[i], 32'hffff_ffff);
            rd_chk(adr_t[i], msk_t[i]);
        end
        // byte lanes 0 and 2 only
        wb_access(1'b1, mcr_pkg::OFS_SUBST_0, 4'h5, 32'haaaa_bbbb);
        rd_chk(mcr_pkg::OFS_SUBST_0, 32'hffaa_ffbb);
        // one engine at a time, then release all
        for (int i = 0; i < 4; i++) begin
            wr(mcr_pkg::OFS_ENGINE_RESET, (32'h1 << i) & 32'h7);
            check({audio_reset, touch_reset, coproc_reset}, (32'h1 << i) & 32'h7);
            rd_chk(mcr_pkg::OFS_ENGINE_RESET, (32'h1 << i) & 32'h7);
        end
        // back-to-back substitution requests for both words
        wr(mcr_pkg::OFS_SUBST_0, 32'h1234_5678);
        wr(mcr_pkg::OFS_SUBST_1, 32'h9abc_def0);
        subst_req <= 1'b1;
        subst_param <= 1'b0;
        subst_addr <= 13'h0005;
        @(posedge clk);
        subst_param <= 1'b1;
        subst_addr <= 13'h1fff;
        @(posedge clk);
        subst_req <= 1'b0;
        check({dl_wr_en, 18'h0_0000, dl_wr_addr}, 32'h8000_0005);
        check(dl_wr_data, 32'h1234_5678);
        @(posedge clk);
        check({dl_wr_en, 18'h0_0000, dl_wr_addr}, 32'h8000_1fff);
        check(dl_wr_data, 32'h9abc_def0);
        // legal frequency of 100 Hz; count high cycles over one period
        wr(mcr_pkg::OFS_BL_FREQ, 32'h0000_0064);
        for (int i = 0; i < 5; i++) begin
            wr(mcr_pkg::OFS_BL_DUTY, duty_t[i]);
            repeat (4) @(posedge clk);
            cnt = 0;
            repeat (256) begin
                @(posedge clk);
                if (backlight_pwm === 1'b1) cnt++;
            end
            check(cnt, high_t[i]);
        end
        // flag raises the line, then gating by global enable and mask
        irq_event <= 8'h08;
        @(posedge clk);
        irq_event <= 8'h00;
        repeat (3) @(posedge clk);
        check(irq_out, 1'b1);
        wr(mcr_pkg::OFS_IRQ_GLOBAL, 32'h0000_0000);
        check(irq_out, 1'b0);
        wr(mcr_pkg::OFS_IRQ_GLOBAL, 32'h0000_0001);
        check(irq_out, 1'b1);
        wr(mcr_pkg::OFS_IRQ_SOURCE, 32'h0000_00f7);
        check(irq_out, 1'b0);
        wr(mcr_pkg::OFS_IRQ_SOURCE, 32'h0000_0000);
        wr(mcr_pkg::OFS_IRQ_SOURCE, 32'h0000_0008);
        check(irq_out, 1'b1);
        rd_chk(mcr_pkg::OFS_IRQ_FLAGS, 32'h0000_0008);
        rd_chk(mcr_pkg::OFS_IRQ_FLAGS, 32'h0000_0000);
        check(irq_out, 1'b0);
        test_done();
    end
endmodule : testbench
